// ==== hdl/port_b_parallel_io.sv ====
// Port B general-purpose parallel port with an APB register slave.
`timescale 1ns/1ps
module port_b_parallel_io
  import port_b_pkg::*;
#(
  parameter int unsigned width = port_width
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire apb_req_s apb_req,
  output apb_rsp_s apb_rsp,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] pin_out,
  output logic [width-1:0] pin_oe,
  output logic [width-1:0] pulldown_en,
  input wire logic [width-1:0] alt_override_en,
  input wire logic [width-1:0] alt_override_val,
  input wire logic [width-1:0] alt_oe,
  output logic [width-1:0] shared_pin_level
);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  logic [width-1:0] direction_r;
  logic [width-1:0] inhibit_r;
  logic global_disable_r;
  logic [31:0] prdata_r;
  logic [width-1:0] latch_q;
  logic [width-1:0] pin_sync;

  wire access_phase = apb_req.psel && apb_req.penable;
  wire wr_strobe = access_phase && apb_req.pwrite && apb_req.pstrb[0];
  wire setup_read = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  wire hit_data = apb_req.paddr == pin_data_addr;
  wire hit_direction = apb_req.paddr == direction_addr;
  wire hit_inhibit = apb_req.paddr == pulldown_inhibit_addr;
  wire hit_config = apb_req.paddr == config_addr;
  wire hit_any = hit_data || hit_direction || hit_inhibit || hit_config;
  wire wr_data = wr_strobe && hit_data;
  wire wr_direction = wr_strobe && hit_direction;
  wire wr_inhibit = wr_strobe && hit_inhibit;
  wire wr_config = wr_strobe && hit_config;
  wire [width-1:0] wbyte = apb_req.pwdata[width-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Pin data latch and pin synchroniser.

  port_b_latch #(
    .width(width)
  ) u_latch (
    .mclk(mclk),
    .wr_en(wr_data),
    .wr_data(wbyte),
    .latch_q(latch_q)
  );

  port_b_sync #(
    .width(width)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      direction_r <= width'(direction_reset);
      inhibit_r <= width'(inhibit_reset);
      global_disable_r <= config_global_disable_reset;
    end else begin
      if (wr_direction) begin
        direction_r <= wbyte;
      end
      if (wr_inhibit) begin
        inhibit_r <= wbyte;
      end
      if (wr_config) begin
        global_disable_r <= apb_req.pwdata[config_global_disable_bit];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Output pins read the latch, inputs read the thresholded synchronised level.
  wire [width-1:0] data_view = (direction_r & latch_q) | (~direction_r & pin_sync);

  function automatic logic [31:0] widen(input logic [width-1:0] v);
    widen = {{(32 - width){1'b0}}, v};
  endfunction

  wire [31:0] rd_mux = hit_data ? widen(data_view) :
                       hit_direction ? widen(direction_r) :
                       hit_config ? {31'h0000_0000, global_disable_r} :
                       undefined_read;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_read) begin
      prdata_r <= rd_mux;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access_phase && !hit_any;
  assign apb_rsp.prdata = prdata_r;

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive.

  // Low pins carry no override; the attached modules only read their level.
  localparam logic [width-1:0] override_mask = ~width'((1 << shared_low_pins) - 1);
  wire [width-1:0] ov_en = alt_override_en & override_mask;
  wire [width-1:0] ov_oe = alt_oe & override_mask;
  wire [width-1:0] drive_oe = direction_r | ov_oe;

  assign pin_out = (ov_en & alt_override_val) | (~ov_en & latch_q);
  assign pin_oe = drive_oe;
  // Any enabled output or an inhibit bit at one removes the pulldown.
  assign pulldown_en = {width{!global_disable_r}} & ~inhibit_r & ~drive_oe;
  assign shared_pin_level = pin_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence dir_write_s;
    wr_direction;
  endsequence

  // A read whose setup cycle addresses the data register.
  sequence data_read_setup_s;
    setup_read && hit_data;
  endsequence

  // A read whose setup cycle addresses the direction register.
  sequence dir_read_setup_s;
    setup_read && hit_direction;
  endsequence

  // A read whose setup cycle addresses the write-only inhibit register.
  sequence inhibit_read_setup_s;
    setup_read && hit_inhibit;
  endsequence

  a_read_direction: assert property (@(posedge mclk) disable iff (!resetn)
    dir_read_setup_s |=> prdata_r[width-1:0] == $past(direction_r)) else $error("direction read wrong");
  a_read_input: assert property (@(posedge mclk) disable iff (!resetn)
    data_read_setup_s |=> (prdata_r[width-1:0] & ~$past(direction_r)) == ($past(pin_sync) & ~$past(direction_r)))
    else $error("input read wrong");
  a_inhibit_read: assert property (@(posedge mclk) disable iff (!resetn)
    inhibit_read_setup_s |=> prdata_r == undefined_read) else $error("inhibit read not fixed");
  a_inhibit_update: assert property (@(posedge mclk) disable iff (!resetn)
    wr_inhibit |=> inhibit_r == $past(wbyte)) else $error("inhibit not updated");
  a_latch_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !wr_data |=> $stable(latch_q)) else $error("latch changed without write");
  a_low_pins_plain: assert property (@(posedge mclk) disable iff (!resetn)
    (pin_oe[0] == direction_r[0]) && (pin_out[0] == latch_q[0])) else $error("low pin overridden");
  a_pulldown_bit: assert property (@(posedge mclk) disable iff (!resetn)
    pulldown_en[2] == (!global_disable_r && !inhibit_r[2] && !pin_oe[2])) else $error("pulldown enable wrong");

  a_direction_update: assert property (@(posedge mclk) disable iff (!resetn)
    dir_write_s |=> direction_r == $past(wbyte)) else $error("direction not updated");
  a_latch_write: assert property (@(posedge mclk) disable iff (!resetn)
    wr_data |=> latch_q == $past(wbyte)) else $error("latch not written");
  a_output_drive: assert property (@(posedge mclk) disable iff (!resetn)
    (direction_r[0] && !ov_en[0]) |-> pin_out[0] == latch_q[0] && pin_oe[0]) else $error("output drive wrong");
  a_pulldown_off_out: assert property (@(posedge mclk) disable iff (!resetn)
    (direction_r != '0) |-> (pulldown_en & direction_r) == '0) else $error("pulldown on output");
  a_inhibit_off: assert property (@(posedge mclk) disable iff (!resetn)
    (pulldown_en & inhibit_r) == '0) else $error("inhibited pulldown on");
  a_pulldown_on: assert property (@(posedge mclk) disable iff (!resetn)
    (!global_disable_r && !inhibit_r[1] && !drive_oe[1]) |-> pulldown_en[1]) else $error("pulldown missing");
  a_global_off: assert property (@(posedge mclk) disable iff (!resetn)
    global_disable_r |-> pulldown_en == '0) else $error("global disable ignored");
  a_read_output: assert property (@(posedge mclk) disable iff (!resetn)
    (setup_read && hit_data) ##1 (apb_req.penable && $stable(direction_r) && $stable(latch_q)) |->
    (prdata_r[width-1:0] & direction_r) == (latch_q & direction_r)) else $error("output read wrong");
  // Attempts that begin within a cycle of reset release would compare against flops still held clear.
  a_sync_delay: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn) |-> ##2 shared_pin_level == $past(pin_in, 2)) else $error("synchroniser depth wrong");
  a_reset_dir: assert property (@(posedge mclk) $rose(resetn) |-> direction_r == '0 && inhibit_r == '0)
    else $error("reset values wrong");

endmodule

// ==== hdl/port_b_pkg.sv ====
// Package holding register map, field layouts and carrier structs for the port B block.
package port_b_pkg;

  localparam int unsigned port_width = 8;
  localparam int unsigned addr_width = 12;
  localparam int unsigned shared_low_pins = 4;

  localparam logic [addr_width-1:0] pin_data_addr = 12'h004;
  localparam logic [addr_width-1:0] direction_addr = 12'h008;
  localparam logic [addr_width-1:0] pulldown_inhibit_addr = 12'h00c;
  localparam logic [addr_width-1:0] config_addr = 12'h010;

  localparam logic [port_width-1:0] direction_reset = 8'h00;
  localparam logic [port_width-1:0] inhibit_reset = 8'h00;
  localparam logic [port_width-1:0] latch_init = 8'h00;
  localparam logic [31:0] undefined_read = 32'h0000_0000;
  localparam int unsigned config_global_disable_bit = 0;
  localparam logic config_global_disable_reset = 1'b0;

  typedef enum logic [1:0] {
    sel_none,
    sel_data,
    sel_direction,
    sel_other
  } reg_sel_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [addr_width-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic [port_width-1:0] out_val;
    logic [port_width-1:0] out_en;
    logic [port_width-1:0] pulldown_en;
  } pin_drive_s;

endpackage

// ==== hdl/port_b_sync.sv ====
// Two-stage synchroniser for the port pin levels.
`timescale 1ns/1ps
module port_b_sync
  import port_b_pkg::*;
#(
  parameter int unsigned width = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);

  logic [width-1:0] stage1_r;
  logic [width-1:0] stage2_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;

endmodule

// ==== hdl/port_b_latch.sv ====
// Port data latch that ignores reset and accepts every write.
`timescale 1ns/1ps
module port_b_latch
  import port_b_pkg::*;
#(
  parameter int unsigned width = 8
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [width-1:0] wr_data,
  output logic [width-1:0] latch_q
);

  logic [width-1:0] latch_r = width'(latch_init);

  // The latch has no reset connection so its content survives a reset.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      latch_r <= wr_data;
    end
  end

  assign latch_q = latch_r;

endmodule

// ==== verif/port_b_pins.sv ====
// Pin-side model: outside drivers and pulldowns resolve each pin level.
`timescale 1ns/1ps
module port_b_pins (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pulldown_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin_in
);
  // A floating pin with its pulldown off shows the inverse of the port drive, so a stale value never looks right.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val) | (~pin_oe & ~ext_drv & ~pulldown_en & ~pin_out);
endmodule

// ==== verif/port_b_parallel_io_tb.sv ====
// Self-checking bench for the port B parallel port.
`timescale 1ns/1ps
module port_b_parallel_io_tb;
  import port_b_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  logic [7:0] pin_in, pin_out, pin_oe, pd_en, lvl;
  logic [7:0] ov_en = 8'h00, ov_val = 8'h00, alt_oe = 8'h00, ext_val = 8'h00, ext_drv = 8'hff;
  logic [31:0] rd;
  logic err;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #2.5 mclk = ~mclk;
  port_b_parallel_io port_b_parallel_io_i (.mclk(mclk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pulldown_en(pd_en), .alt_override_en(ov_en),
    .alt_override_val(ov_val), .alt_oe(alt_oe), .shared_pin_level(lvl));
  port_b_pins port_b_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .pulldown_en(pd_en), .ext_val(ext_val),
    .ext_drv(ext_drv), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [addr_width-1:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}, pstrb: 4'hf};
    @(posedge mclk);
    req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1) @(posedge mclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rd_chk(input string what, input logic [addr_width-1:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    check(what, rd, {24'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    settle(1);
    check("pin_oe", pin_oe, 8'h00);
    check("pulldown_en", pd_en, 8'hff);
    rd_chk("direction", direction_addr, direction_reset);
    rd_chk("inhibit", pulldown_inhibit_addr, 8'h00);
    xfer(12'hffc, 1'b1, 8'h5a);
    check("pslverr", err, 32'h1);
    $display("test reset done");
  endtask
  task automatic t_data;
    @(posedge mclk);
    ext_val <= 8'h96;
    xfer(pin_data_addr, 1'b1, 8'h3c);
    settle(3);
    rd_chk("data input", pin_data_addr, 8'h96);
    xfer(direction_addr, 1'b1, 8'h0f);
    settle(1);
    check("pin_oe", pin_oe, 8'h0f);
    check("pin_out", pin_out, 8'h3c);
    rd_chk("data mixed", pin_data_addr, 8'h9c);
    rd_chk("direction", direction_addr, 8'h0f);
    check("pulldown_en", pd_en, 8'hf0);
    $display("test data done");
  endtask
  task automatic t_pull;
    xfer(pulldown_inhibit_addr, 1'b1, 8'ha5);
    settle(1);
    check("pulldown_en", pd_en, 8'h50);
    rd_chk("inhibit", pulldown_inhibit_addr, 8'h00);
    xfer(config_addr, 1'b1, 8'h01);
    settle(1);
    check("pulldown_en", pd_en, 8'h00);
    xfer(config_addr, 1'b1, 8'h00);
    xfer(pulldown_inhibit_addr, 1'b1, 8'h00);
    settle(1);
    check("pulldown_en", pd_en, 8'hf0);
    $display("test pulldown done");
  endtask
  task automatic t_keep;
    @(posedge mclk);
    resetn <= 1'b0;
    settle(2);
    check("pin_oe", pin_oe, 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    xfer(direction_addr, 1'b1, 8'hff);
    settle(1);
    check("pin_out", pin_out, 8'h3c);
    rd_chk("data kept", pin_data_addr, 8'h3c);
    $display("test latch keep done");
  endtask
  task automatic t_shared;
    xfer(direction_addr, 1'b1, 8'h00);
    @(posedge mclk);
    ov_en <= 8'hff;
    ov_val <= 8'ha0;
    alt_oe <= 8'hff;
    ext_val <= 8'h69;
    ext_drv <= 8'h0f;
    settle(1);
    check("pin_oe", pin_oe, 8'hf0);
    check("pin_out", pin_out, 8'hac);
    check("pulldown_en", pd_en, 8'h0f);
    settle(1);
    check("shared level", lvl, 8'ha9);
    rd_chk("data shared", pin_data_addr, 8'ha9);
    xfer(pulldown_inhibit_addr, 1'b1, 8'hff);
    settle(1);
    check("pulldown_en", pd_en, 8'h00);
    $display("test shared done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_data();
    t_pull();
    t_keep();
    t_shared();
    finish_test();
  end
endmodule
